/* ddr_link_pkg.sv */
// Shared constants and types for both ends of the DDR command/data link
package ddr_link_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int BANKS   = 4;
   localparam int BANK_W  = 2;
   localparam int ADDR_W  = 13;
   localparam int LANES   = 2;
   localparam int LANE_W  = 8;
   localparam int DQ_W    = LANES * LANE_W;
   localparam int BEATS   = 2;
   localparam int BURST_W = BEATS * DQ_W;
   localparam int MASK_W  = BEATS * LANES;

   // ****************************************************
   // Field positions, reset values and mode register select codes
   // ****************************************************
   localparam int PRE_FLAG_BIT = 10;
   localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
   localparam logic [BANK_W-1:0] SEL_BASE_MODE = 2'h0;
   localparam logic [BANK_W-1:0] SEL_EXT_MODE  = 2'h1;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int REF_CLK_NS = 40;
   localparam int CK_DIV     = 4;
   localparam int LINK_CK_NS = REF_CLK_NS * CK_DIV;

   // ****************************************************
   // Command codes as {row strobe, column strobe, write enable}
   // ****************************************************
   typedef enum logic [2:0] {
      CMD_LOAD    = 3'h0,
      CMD_REFRESH = 3'h1,
      CMD_PRE     = 3'h2,
      CMD_ACT     = 3'h3,
      CMD_WR      = 3'h4,
      CMD_RD      = 3'h5,
      CMD_STOP    = 3'h6,
      CMD_NOP     = 3'h7
   } cmd_t;

   // Requests on the controller user side
   typedef enum logic [2:0] {
      OP_NOP  = 3'h0,
      OP_ACT  = 3'h1,
      OP_RD   = 3'h2,
      OP_WR   = 3'h3,
      OP_PRE  = 3'h4,
      OP_LOAD = 3'h5
   } req_op_t;

   // Quarter of a link clock period, Gray coded
   typedef enum logic [1:0] {
      PH_RISE = 2'h0,
      PH_HIGH = 2'h1,
      PH_FALL = 2'h3,
      PH_LOW  = 2'h2
   } phase_t;

endpackage : ddr_link_pkg

/* ddr_link_if.sv */
// Link wires between controller end and memory end, with two-way resolution
`timescale 1ns/1ps
interface ddr_link_if;
   import ddr_link_pkg::*;

   logic                ck;
   logic                ck_n;
   logic                cs_n;
   logic                ras_n;
   logic                cas_n;
   logic                we_n;
   logic [BANK_W-1:0]   ba;
   logic [ADDR_W-1:0]   addr;
   logic [LANES-1:0]    dm;
   logic [DQ_W-1:0]     ctl_dq;
   logic                ctl_dq_oe_n;
   logic [LANES-1:0]    ctl_dqs;
   logic                ctl_dqs_oe_n;
   logic [DQ_W-1:0]     mem_dq;
   logic                mem_dq_oe_n;
   logic [LANES-1:0]    mem_dqs;
   logic                mem_dqs_oe_n;
   logic [DQ_W-1:0]     dq;
   logic [LANES-1:0]    dqs;

   // Undriven wires settle low
   assign dq  = !ctl_dq_oe_n ? ctl_dq : (!mem_dq_oe_n ? mem_dq : '0);
   assign dqs = !ctl_dqs_oe_n ? ctl_dqs : (!mem_dqs_oe_n ? mem_dqs : '0);

   modport ctrl (
      output ck, ck_n, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
      output ctl_dq, ctl_dq_oe_n, ctl_dqs, ctl_dqs_oe_n,
      input  dq, dqs
   );

   modport mem (
      input  ck, ck_n, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq, dqs,
      output mem_dq, mem_dq_oe_n, mem_dqs, mem_dqs_oe_n
   );

endinterface : ddr_link_if

/* ddr_ctrl_end.sv */
// Controller end: makes the link clock, issues commands, moves burst data
`timescale 1ns/1ps
module ddr_ctrl_end (
   input  wire logic                               I_REF_CLK,
   input  wire logic                               I_RESET,
   ddr_link_if.ctrl                                LINK,
   input  wire logic                               I_REQ_VALID,
   output logic                                    O_REQ_READY,
   input  wire ddr_link_pkg::req_op_t              I_REQ_OP,
   input  wire logic [ddr_link_pkg::BANK_W-1:0]    I_REQ_BANK,
   input  wire logic [ddr_link_pkg::ADDR_W-1:0]    I_REQ_ADDR,
   input  wire logic                               I_REQ_FLAG,
   input  wire logic [ddr_link_pkg::BURST_W-1:0]   I_REQ_WDATA,
   input  wire logic [ddr_link_pkg::MASK_W-1:0]    I_REQ_WMASK,
   output logic                                    O_RD_VALID,
   output logic [ddr_link_pkg::BURST_W-1:0]        O_RD_DATA
);
   import ddr_link_pkg::*;

   phase_t               phase_q, phase_d;
   logic                 ck_q, ck_d;
   logic                 cs_n_q, cs_n_d;
   cmd_t                 cmd_q, cmd_d;
   logic [BANK_W-1:0]    ba_q, ba_d;
   logic [ADDR_W-1:0]    addr_q, addr_d;
   logic [BURST_W-1:0]   wd_q, wd_d;
   logic [MASK_W-1:0]    wm_q, wm_d;
   logic [DQ_W-1:0]      hi_q, hi_d;
   logic [LANES-1:0]     him_q, him_d;
   logic                 wr_q, wr_d, rd_q, rd_d;
   logic                 wr_act_q, wr_act_d, rd_act_q, rd_act_d;
   logic [DQ_W-1:0]      dq_q, dq_d;
   logic [LANES-1:0]     dm_q, dm_d;
   logic                 dq_oe_n_q, dq_oe_n_d;
   logic [LANES-1:0]     dqs_q, dqs_d;
   logic                 dqs_oe_n_q, dqs_oe_n_d;
   logic [BURST_W-1:0]   rdat_q, rdat_d;
   logic                 rvalid_q, rvalid_d;
   logic                 take;
   logic                 rst_q;

   // Requests are taken only while the link clock is high
   assign O_REQ_READY = !I_RESET && (phase_q == PH_HIGH);
   assign take        = I_REQ_VALID && O_REQ_READY;

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      phase_d    = phase_q;
      ck_d       = ck_q;
      cs_n_d     = cs_n_q;
      cmd_d      = cmd_q;
      ba_d       = ba_q;
      addr_d     = addr_q;
      wd_d       = wd_q;
      wm_d       = wm_q;
      hi_d       = hi_q;
      him_d      = him_q;
      wr_d       = wr_q;
      rd_d       = rd_q;
      wr_act_d   = wr_act_q;
      rd_act_d   = rd_act_q;
      dq_d       = dq_q;
      dm_d       = dm_q;
      dq_oe_n_d  = dq_oe_n_q;
      dqs_d      = dqs_q;
      dqs_oe_n_d = dqs_oe_n_q;
      rdat_d     = rdat_q;
      rvalid_d   = 1'b0;
      unique case (phase_q)
         PH_HIGH: begin
            // Link clock falls; command changes half a period before its sampling edge
            phase_d = PH_FALL;
            ck_d    = 1'b0;
            cs_n_d  = 1'b1;
            cmd_d   = CMD_NOP;
            ba_d    = '0;
            addr_d  = '0;
            wr_d    = 1'b0;
            rd_d    = 1'b0;
            if (take) begin
               cs_n_d = 1'b0;
               ba_d   = I_REQ_BANK;
               wd_d   = I_REQ_WDATA;
               wm_d   = I_REQ_WMASK;
               unique case (I_REQ_OP)
                  OP_ACT: begin
                     cmd_d  = CMD_ACT;
                     addr_d = I_REQ_ADDR;
                  end
                  OP_RD, OP_WR: begin
                     cmd_d  = (I_REQ_OP == OP_RD) ? CMD_RD : CMD_WR;
                     rd_d   = (I_REQ_OP == OP_RD);
                     wr_d   = (I_REQ_OP == OP_WR);
                     addr_d[PRE_FLAG_BIT-1:0] = I_REQ_ADDR[PRE_FLAG_BIT-1:0];
                     addr_d[PRE_FLAG_BIT]     = I_REQ_FLAG;
                  end
                  OP_PRE: begin
                     cmd_d  = CMD_PRE;
                     addr_d[PRE_FLAG_BIT] = I_REQ_FLAG;
                  end
                  OP_LOAD: begin
                     cmd_d  = CMD_LOAD;
                     addr_d = I_REQ_ADDR;
                  end
                  default: begin
                     cmd_d  = CMD_NOP;
                  end
               endcase
            end
            if (wr_act_q) begin
               dq_d = hi_q;
               dm_d = him_q;
            end
         end
         PH_FALL: begin
            phase_d = PH_LOW;
            // Falling strobe in the middle of the second beat
            if (wr_act_q) begin
               dqs_d = '0;
            end
            if (rd_act_q) begin
               rdat_d[DQ_W +: DQ_W] = LINK.dq;
               rvalid_d = 1'b1;
            end
         end
         PH_LOW: begin
            phase_d  = PH_RISE;
            ck_d     = 1'b1;
            wr_act_d = wr_q;
            rd_act_d = rd_q;
            dq_oe_n_d  = !wr_q;
            dqs_oe_n_d = !wr_q;
            dqs_d      = '0;
            dm_d       = '0;
            if (wr_q) begin
               dq_d  = wd_q[0 +: DQ_W];
               dm_d  = wm_q[0 +: LANES];
               hi_d  = wd_q[DQ_W +: DQ_W];
               him_d = wm_q[LANES +: LANES];
            end
         end
         PH_RISE: begin
            phase_d = PH_HIGH;
            // Rising strobe in the middle of the first beat
            if (wr_act_q) begin
               dqs_d = '1;
            end
            if (rd_act_q) begin
               rdat_d[0 +: DQ_W] = LINK.dq;
            end
         end
      endcase
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         // Link clock starts from a known level, then keeps running so the memory end resets
         rst_q      <= 1'b1;
         if (rst_q) begin
            phase_q <= phase_d;
            ck_q    <= ck_d;
         end else begin
            phase_q <= PH_HIGH;
            ck_q    <= 1'b1;
         end
         cs_n_q     <= 1'b1;
         cmd_q      <= CMD_NOP;
         ba_q       <= '0;
         addr_q     <= '0;
         wd_q       <= '0;
         wm_q       <= '0;
         hi_q       <= '0;
         him_q      <= '0;
         wr_q       <= 1'b0;
         rd_q       <= 1'b0;
         wr_act_q   <= 1'b0;
         rd_act_q   <= 1'b0;
         dq_q       <= '0;
         dm_q       <= '0;
         dq_oe_n_q  <= 1'b1;
         dqs_q      <= '0;
         dqs_oe_n_q <= 1'b1;
         rdat_q     <= '0;
         rvalid_q   <= 1'b0;
      end else begin
         phase_q    <= phase_d;
         ck_q       <= ck_d;
         cs_n_q     <= cs_n_d;
         cmd_q      <= cmd_d;
         ba_q       <= ba_d;
         addr_q     <= addr_d;
         wd_q       <= wd_d;
         wm_q       <= wm_d;
         hi_q       <= hi_d;
         him_q      <= him_d;
         wr_q       <= wr_d;
         rd_q       <= rd_d;
         wr_act_q   <= wr_act_d;
         rd_act_q   <= rd_act_d;
         dq_q       <= dq_d;
         dm_q       <= dm_d;
         dq_oe_n_q  <= dq_oe_n_d;
         dqs_q      <= dqs_d;
         dqs_oe_n_q <= dqs_oe_n_d;
         rdat_q     <= rdat_d;
         rvalid_q   <= rvalid_d;
         rst_q      <= 1'b0;
      end
   end

   assign LINK.ck           = ck_q;
   assign LINK.ck_n         = ~ck_q;
   assign LINK.cs_n         = cs_n_q;
   assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_q;
   assign LINK.ba           = ba_q;
   assign LINK.addr         = addr_q;
   assign LINK.dm           = dm_q;
   assign LINK.ctl_dq       = dq_q;
   assign LINK.ctl_dq_oe_n  = dq_oe_n_q;
   assign LINK.ctl_dqs      = dqs_q;
   assign LINK.ctl_dqs_oe_n = dqs_oe_n_q;
   assign O_RD_VALID        = rvalid_q;
   assign O_RD_DATA         = rdat_q;

endmodule : ddr_ctrl_end

/* ddr_mem_end.sv */
// Memory end: decodes link commands, tracks banks and mode registers, stores bursts
`timescale 1ns/1ps
module ddr_mem_end #(
   parameter int ROW_KEEP = 2,
   parameter int COL_KEEP = 3
) (
   input  wire logic                               I_RESET,
   ddr_link_if.mem                                 LINK,
   output logic [ddr_link_pkg::BANKS-1:0]          O_BANK_OPEN,
   output logic [ddr_link_pkg::ADDR_W-1:0]         O_MODE_REG,
   output logic [ddr_link_pkg::ADDR_W-1:0]         O_EXT_MODE_REG
);
   import ddr_link_pkg::*;

   localparam int MEM_AW = BANK_W + ROW_KEEP + COL_KEEP;
   localparam int DEPTH  = 1 << MEM_AW;

   logic                 clk;
   logic [DQ_W-1:0]      wr_beat0;
   logic [DQ_W-1:0]      wr_beat1;
   logic [LANES-1:0]     wr_mask0;
   logic [LANES-1:0]     wr_mask1;

   logic [BANKS-1:0]     open_q, open_d;
   logic [ADDR_W-1:0]    row_q [BANKS];
   logic [ADDR_W-1:0]    row_d [BANKS];
   logic [ADDR_W-1:0]    mr_q, mr_d;
   logic [ADDR_W-1:0]    emr_q, emr_d;
   logic                 wr_pend_q, wr_pend_d;
   logic [MEM_AW-1:0]    wr_idx_q, wr_idx_d;
   logic                 rd_act_q, rd_act_d;
   logic [DQ_W-1:0]      rd_b0_q, rd_b0_d;
   logic [DQ_W-1:0]      rd_b1_q, rd_b1_d;
   logic [DQ_W-1:0]      mem_q [DEPTH];
   logic [DQ_W-1:0]      mem_d [DEPTH];

   logic [BANK_W-1:0]    bank;
   cmd_t                 code;
   logic                 flag;
   logic [MEM_AW-1:0]    idx;
   logic [MEM_AW-1:0]    one_idx;

   // Control side runs on the true link clock
   assign clk = LINK.ck;

   // ****************************************************
   // Write capture on the data strobes
   // ****************************************************
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] dq_rise_q;
      logic [LANE_W-1:0] dq_fall_q;
      logic              dm_rise_q;
      logic              dm_fall_q;

      // Each lane is timed by its own strobe
      always_ff @(posedge LINK.dqs[g]) begin
         dq_rise_q <= LINK.dq[g*LANE_W +: LANE_W];
         dm_rise_q <= LINK.dm[g];
      end

      always_ff @(negedge LINK.dqs[g]) begin
         dq_fall_q <= LINK.dq[g*LANE_W +: LANE_W];
         dm_fall_q <= LINK.dm[g];
      end

      // Captures are stable a quarter period before the committing edge
      assign wr_beat0[g*LANE_W +: LANE_W] = dq_rise_q;
      assign wr_beat1[g*LANE_W +: LANE_W] = dq_fall_q;
      assign wr_mask0[g] = dm_rise_q;
      assign wr_mask1[g] = dm_fall_q;
   end

   // ****************************************************
   // Command decode
   // ****************************************************
   assign bank    = LINK.ba;
   assign code    = cmd_t'({LINK.ras_n, LINK.cas_n, LINK.we_n});
   assign flag    = LINK.addr[PRE_FLAG_BIT];
   assign idx     = {bank, row_q[bank][ROW_KEEP-1:0],
                     LINK.addr[COL_KEEP-1:0]};
   assign one_idx = {{(MEM_AW-1){1'b0}}, 1'b1};

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      open_d    = open_q;
      row_d     = row_q;
      mr_d      = mr_q;
      emr_d     = emr_q;
      wr_pend_d = 1'b0;
      wr_idx_d  = wr_idx_q;
      rd_act_d  = 1'b0;
      rd_b0_d   = rd_b0_q;
      rd_b1_d   = rd_b1_q;
      mem_d     = mem_q;

      // Commit the burst taken during the previous link period
      if (wr_pend_q) begin
         for (int l = 0; l < LANES; l++) begin
            if (!wr_mask0[l]) begin
               mem_d[wr_idx_q][l*LANE_W +: LANE_W] = wr_beat0[l*LANE_W +: LANE_W];
            end
            if (!wr_mask1[l]) begin
               mem_d[wr_idx_q ^ one_idx][l*LANE_W +: LANE_W] =
                  wr_beat1[l*LANE_W +: LANE_W];
            end
         end
      end

      if (!LINK.cs_n) begin
         unique case (code)
            CMD_ACT: begin
               open_d[bank] = 1'b1;
               row_d[bank]  = LINK.addr;
            end
            CMD_RD: begin
               if (open_q[bank]) begin
                  rd_act_d = 1'b1;
                  rd_b0_d  = mem_d[idx];
                  rd_b1_d  = mem_d[idx ^ one_idx];
                  if (flag) begin
                     open_d[bank] = 1'b0;
                  end
               end
            end
            CMD_WR: begin
               if (open_q[bank]) begin
                  wr_pend_d = 1'b1;
                  wr_idx_d  = idx;
                  if (flag) begin
                     open_d[bank] = 1'b0;
                  end
               end
            end
            CMD_PRE: begin
               if (flag) begin
                  open_d = '0;
               end else begin
                  open_d[bank] = 1'b0;
               end
            end
            CMD_LOAD: begin
               if (bank == SEL_BASE_MODE) begin
                  mr_d = LINK.addr;
               end else if (bank == SEL_EXT_MODE) begin
                  emr_d = LINK.addr;
               end
            end
            CMD_REFRESH, CMD_STOP, CMD_NOP: begin
            end
         endcase
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         open_q    <= '0;
         row_q     <= '{default: '0};
         mr_q      <= MODE_RST;
         emr_q     <= MODE_RST;
         wr_pend_q <= 1'b0;
         wr_idx_q  <= '0;
         rd_act_q  <= 1'b0;
         rd_b0_q   <= '0;
         rd_b1_q   <= '0;
      end else begin
         open_q    <= open_d;
         row_q     <= row_d;
         mr_q      <= mr_d;
         emr_q     <= emr_d;
         wr_pend_q <= wr_pend_d;
         wr_idx_q  <= wr_idx_d;
         rd_act_q  <= rd_act_d;
         rd_b0_q   <= rd_b0_d;
         rd_b1_q   <= rd_b1_d;
      end
   end

   // Storage array keeps its contents through reset
   always_ff @(posedge clk) begin
      mem_q <= mem_d;
   end

   // ****************************************************
   // Read drive
   // ****************************************************
   // First beat while the clock is high, second while low; strobe follows the clock
   assign LINK.mem_dq       = clk ? rd_b0_q : rd_b1_q;
   assign LINK.mem_dqs      = {LANES{clk}};
   assign LINK.mem_dq_oe_n  = !rd_act_q;
   assign LINK.mem_dqs_oe_n = !rd_act_q;

   assign O_BANK_OPEN    = open_q;
   assign O_MODE_REG     = mr_q;
   assign O_EXT_MODE_REG = emr_q;

endmodule : ddr_mem_end

/* ddr_link_properties.sv */
// Checker for clock, command and strobe relations on the link wires
`timescale 1ns/1ps
module ddr_link_properties
   import ddr_link_pkg::*;
(
   input wire logic              I_REF_CLK,
   input wire logic              I_RESET,
   input wire logic              ck,
   input wire logic              ck_n,
   input wire logic              cs_n,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [LANES-1:0]  dm,
   input wire logic              ctl_dq_oe_n,
   input wire logic              ctl_dqs_oe_n,
   input wire logic              mem_dqs_oe_n,
   input wire logic [DQ_W-1:0]   dq,
   input wire logic [LANES-1:0]  dqs
);
   logic [2:0] cmd;
   assign cmd = {ras_n, cas_n, we_n};
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   // ****
   // Command framing
   // ****
   sequence s_new_cmd;
      !cs_n && $changed({cs_n, cmd, ba, addr});
   endsequence
   sequence s_hold;
      $stable({cs_n, cmd, ba, addr}) [*3];
   endsequence
   AST_CK_COMPL: assert property (ck_n == ~ck)
      else $error("link clock pair not complementary");
   AST_CMD_ALIGN: assert property ($rose(ck) |-> $stable({cs_n, cmd, ba, addr}))
      else $error("command moved at link clock rise");
   AST_CMD_HOLD: assert property (s_new_cmd |=> s_hold)
      else $error("command not held for a link period");
   AST_RD_DRIVE: assert property ($fell(mem_dqs_oe_n) |-> !cs_n && cmd == CMD_RD)
      else $error("memory drove strobe without read");
   AST_WR_DRIVE: assert property ($fell(ctl_dq_oe_n) |-> !cs_n && cmd == CMD_WR)
      else $error("controller drove data without write");
   AST_ONE_DRIVER: assert property (!mem_dqs_oe_n |-> ctl_dqs_oe_n)
      else $error("both ends drive strobe");
   AST_RD_EDGE: assert property (!mem_dqs_oe_n && $changed(dq) |-> $changed(dqs))
      else $error("read data moved without strobe edge");
   AST_WR_CENTRE: assert property (!ctl_dqs_oe_n && $changed(dqs) |-> $stable(dq))
      else $error("write data moved at strobe edge");
   AST_DM_EDGE: assert property (!ctl_dqs_oe_n && $changed(dqs) |-> $stable(dm))
      else $error("mask moved at strobe edge");
   AST_LANES: assert property (!mem_dqs_oe_n |-> dqs[0] == dqs[1])
      else $error("read strobe lanes differ");
endmodule : ddr_link_properties

/* ddr_sdram_cmd_addr_pins_bench.sv */
// Testbench joining controller end and memory end across the link
`timescale 1ns/1ps
module ddr_sdram_cmd_addr_pins_bench;
   import ddr_link_pkg::*;
   logic clk;
   logic rst;
   logic valid;
   logic ready;
   req_op_t op;
   logic [1:0] bank;
   logic [12:0] addr;
   logic flag;
   logic [31:0] wdata;
   logic [3:0] wmask;
   logic rd_valid;
   logic [31:0] rd_data;
   logic [3:0] bank_open;
   logic [12:0] mode_reg;
   logic [12:0] ext_mode_reg;
   int error_cnt = 0;
   int n_checks = 0;

   ddr_link_if ddr_link_if_i ();
   ddr_ctrl_end ddr_ctrl_end_i (.I_REF_CLK(clk), .I_RESET(rst), .LINK(ddr_link_if_i),
      .I_REQ_VALID(valid), .O_REQ_READY(ready), .I_REQ_OP(op), .I_REQ_BANK(bank),
      .I_REQ_ADDR(addr), .I_REQ_FLAG(flag), .I_REQ_WDATA(wdata), .I_REQ_WMASK(wmask),
      .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data));
   ddr_mem_end ddr_mem_end_i (.I_RESET(rst), .LINK(ddr_link_if_i), .O_BANK_OPEN(bank_open),
      .O_MODE_REG(mode_reg), .O_EXT_MODE_REG(ext_mode_reg));
   ddr_link_properties ddr_link_properties_i (.I_REF_CLK(clk), .I_RESET(rst),
      .ck(ddr_link_if_i.ck), .ck_n(ddr_link_if_i.ck_n), .cs_n(ddr_link_if_i.cs_n),
      .ras_n(ddr_link_if_i.ras_n), .cas_n(ddr_link_if_i.cas_n), .we_n(ddr_link_if_i.we_n),
      .ba(ddr_link_if_i.ba), .addr(ddr_link_if_i.addr), .dm(ddr_link_if_i.dm),
      .ctl_dq_oe_n(ddr_link_if_i.ctl_dq_oe_n), .ctl_dqs_oe_n(ddr_link_if_i.ctl_dqs_oe_n),
      .mem_dqs_oe_n(ddr_link_if_i.mem_dqs_oe_n), .dq(ddr_link_if_i.dq),
      .dqs(ddr_link_if_i.dqs));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****
   // Shared tasks
   // ****
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic req(input req_op_t o, input logic [1:0] b, input logic [12:0] a,
                      input logic f, input logic [31:0] wd, input logic [3:0] wm);
      int n;
      n = 0;
      @(posedge clk);
      valid <= 1'b1;
      op <= o;
      bank <= b;
      addr <= a;
      flag <= f;
      wdata <= wd;
      wmask <= wm;
      do begin
         @(negedge clk);
         n++;
      end while (ready !== 1'b1 && n < 10);
      chk("req_ready", 32'h1, {31'h0, ready});
      @(posedge clk);
      valid <= 1'b0;
   endtask : req

   task automatic rd(input logic [1:0] b, input logic [12:0] c, input logic f,
                     input logic [31:0] exp);
      int n;
      n = 0;
      req(OP_RD, b, c, f, 32'h0, 4'h0);
      do begin
         @(negedge clk);
         n++;
      end while (rd_valid !== 1'b1 && n < 10);
      chk("rd_valid", 32'h1, {31'h0, rd_valid});
      chk("rd_data", exp, rd_data);
   endtask : rd

   task automatic chk_open(input logic [3:0] exp);
      repeat (6) @(posedge clk);
      chk("bank_open", {28'h0, exp}, {28'h0, bank_open});
   endtask : chk_open

   // ****
   // Scenarios
   // ****
   task automatic t_mode();
      chk("mode_rst", {19'h0, MODE_RST}, {19'h0, mode_reg});
      req(OP_LOAD, SEL_BASE_MODE, 13'h0a5a, 1'b0, 32'h0, 4'h0);
      req(OP_LOAD, SEL_EXT_MODE, 13'h1234, 1'b0, 32'h0, 4'h0);
      req(OP_LOAD, 2'h2, 13'h1fff, 1'b1, 32'h0, 4'h0);
      repeat (6) @(posedge clk);
      chk("mode_reg", 32'h0a5a, {19'h0, mode_reg});
      chk("ext_mode_reg", 32'h1234, {19'h0, ext_mode_reg});
   endtask : t_mode

   task automatic t_act();
      req(OP_ACT, 2'h1, 13'h0005, 1'b0, 32'h0, 4'h0);
      chk_open(4'h2);
      req(OP_ACT, 2'h2, 13'h1fff, 1'b1, 32'h0, 4'h0);
      req(OP_ACT, 2'h0, 13'h0000, 1'b0, 32'h0, 4'h0);
      req(OP_ACT, 2'h3, 13'h0002, 1'b0, 32'h0, 4'h0);
      chk_open(4'hf);
   endtask : t_act

   task automatic t_wr_rd();
      req(OP_WR, 2'h1, 13'h0004, 1'b0, 32'hbeef_1234, 4'h0);
      req(OP_WR, 2'h1, 13'h0004, 1'b0, 32'h5566_7788, 4'h6);
      rd(2'h1, 13'h0004, 1'b0, 32'h55ef_1288);
      rd(2'h1, 13'h0005, 1'b0, 32'h1288_55ef);
   endtask : t_wr_rd

   task automatic t_pre();
      req(OP_PRE, 2'h3, 13'h0000, 1'b0, 32'h0, 4'h0);
      chk_open(4'h7);
      rd(2'h1, 13'h0004, 1'b1, 32'h55ef_1288);
      chk_open(4'h5);
      req(OP_PRE, 2'h0, 13'h0000, 1'b1, 32'h0, 4'h0);
      chk_open(4'h0);
      rd(2'h1, 13'h0004, 1'b0, 32'h0);
   endtask : t_pre

   task automatic stop_test();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      valid = 1'b0;
      op = OP_NOP;
      bank = 2'h0;
      addr = 13'h0;
      flag = 1'b0;
      wdata = 32'h0;
      wmask = 4'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_mode();
      t_act();
      t_wr_rd();
      t_pre();
      stop_test();
   end
endmodule : ddr_sdram_cmd_addr_pins_bench
